//--- logic/cbio_pkg.sv
/*
 * Shared constants for the branch and flag-out instruction group: opcodes,
 * register byte offsets, field positions, reset values and cycle counts.
 * Assumes a 10-bit instruction word and a 16-bit program counter.
 */
package cbio_pkg;
    localparam logic [9:0] OP_DISP_TOGGLE = 10'h320;
    localparam logic [9:0] OP_FLAG_LOAD   = 10'h258;
    localparam logic [9:0] OP_FLAG_XCHG   = 10'h2D8;
    localparam logic [9:0] OP_G_LOAD      = 10'h058;
    localparam logic [9:0] OP_KEY_BRANCH  = 10'h230;
    localparam logic [1:0] BANK_OP_HI     = 2'h1;
    localparam logic [5:0] BANK_OP_LO     = 6'h00;
    localparam logic [1:0] LONG_FIRST_TAG = 2'h1;
    localparam logic [1:0] LONG_CARRY_TAG = 2'h3;
    localparam logic [2:0] REL_CARRY_TAG  = 3'h7;

    localparam logic [7:0] ADR_CTRL  = 8'h00;
    localparam logic [7:0] ADR_PTR   = 8'h04;
    localparam logic [7:0] ADR_STAT  = 8'h08;
    localparam logic [7:0] ADR_C_LO  = 8'h0C;
    localparam logic [7:0] ADR_C_HI  = 8'h10;
    localparam logic [7:0] ADR_GREG  = 8'h14;
    localparam logic [7:0] ADR_PC    = 8'h18;
    localparam logic [7:0] ADR_STATE = 8'h1C;

    localparam int CTRL_RUN   = 0;
    localparam int CTRL_FAST  = 1;
    localparam int CTRL_CARRY = 2;

    localparam logic [15:0] RST_PC      = 16'h0000;
    localparam logic [7:0]  RST_BYTE    = 8'h00;
    localparam logic [55:0] RST_C       = 56'h0;
    localparam logic [3:0]  RST_PTR     = 4'h0;
    localparam logic [1:0]  RST_BANK    = 2'h0;
    localparam logic [3:0]  TOP_DIGIT   = 4'hD;
    localparam logic [3:0]  SYS_PAGE_LAST = 4'h3;

    localparam int NORMAL_CLKS = 10;
    localparam int FAST_CLKS   = 5;
    localparam int PH_SAMPLE   = 3;

    localparam logic [3:0]  KEY_POWER_ROW = 4'h8;
    localparam logic [27:0] KEY_COL_CODES = 28'hFEC8731;

    typedef enum logic [0:0] {
        FETCH_OPCODE = 1'b0,
        FETCH_SECOND = 1'b1
    } cbio_fetch_e;
endpackage

//--- logic/cbio_key_if.sv
/*
 * Carrier for the key code between the key encoder and the decoder core.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface cbio_key_if;
    logic [7:0] key_code;
    logic       key_valid;
    modport enc  (output key_code, output key_valid);
    modport core (input key_code, input key_valid);
endinterface

//--- logic/cbio_keyenc.sv
/*
 * Key encoder: synchronises the key row, power-on and column lines and
 * turns the first active row and column into a key code.
 * Assumes active-high key lines from pins, asynchronous to CLK.
 */
`timescale 1ns/1ps
module cbio_keyenc
    import cbio_pkg::*;
(
    input  wire logic       clk,              // System clock.
    input  wire logic       reset,            // Asynchronous reset, active high.
    input  wire logic [7:0] key_row_lines,    // Row lines from pins.
    input  wire logic       key_power_line,   // Power-on line from pin.
    input  wire logic [6:0] key_column_lines, // Column lines from pins.
    cbio_key_if.enc         key               // Key code towards the core.
);
    logic [15:0] pins_s1_q;
    logic [15:0] pins_s2_q;
    logic [7:0]  code_d;
    logic        valid_d;
    logic [3:0]  row_d;
    logic [3:0]  col_d;
    logic        row_hit;
    logic        col_hit;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pins_s1_q <= 16'h0000;
            pins_s2_q <= 16'h0000;
        end else begin
            pins_s1_q <= {key_power_line, key_column_lines, key_row_lines};
            pins_s2_q <= pins_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // The lowest active row and column win.
    always_comb begin
        row_d   = 4'h0;
        col_d   = 4'h0;
        row_hit = 1'b0;
        col_hit = 1'b0;
        if (pins_s2_q[15]) begin
            row_d   = KEY_POWER_ROW;
            row_hit = 1'b1;
        end
        for (int r = 7; r >= 0; r--) begin
            if (pins_s2_q[r]) begin
                row_d   = 4'(r);
                row_hit = 1'b1;
            end
        end
        for (int k = 6; k >= 0; k--) begin
            if (pins_s2_q[8 + k]) begin
                col_d   = KEY_COL_CODES[k * 4 +: 4];
                col_hit = 1'b1;
            end
        end
        code_d  = {col_d, row_d};
        valid_d = row_hit && col_hit;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            key.key_code  <= RST_BYTE;
            key.key_valid <= 1'b0;
        end else if (valid_d) begin
            key.key_code  <= code_d;
            key.key_valid <= 1'b1;
        end else begin
            key.key_valid <= 1'b0;
        end
    end

    AST_KEY_ROW: assert property (@(posedge clk) disable iff (reset)
        key.key_valid |-> key.key_code[3:0] <= KEY_POWER_ROW
                          && key.key_code[7:4] inside {4'h1, 4'h3, 4'h7, 4'h8,
                                                       4'hC, 4'hE, 4'hF})
        else $error("Key code outside the row and column table.");
endmodule

//--- logic/cbio_core.sv
/*
 * Decode and execute for the display toggle, bank select, flag-out, G-load
 * and carry/key branch instructions, with a classic Wishbone register slave.
 * Assumes program memory answers ISA_ADDR within one clock and that
 * software stops the core (RUN low) before writing processor state.
 */
`timescale 1ns/1ps
module cbio_core
    import cbio_pkg::*;
#(
    parameter int NORMAL_CYC = NORMAL_CLKS,   // Clocks per bus-speed cycle.
    parameter int FAST_CYC   = FAST_CLKS      // Clocks per fast cycle.
) (
    input  wire logic        CLK,              // 50 MHz clock.
    input  wire logic        RESET,            // Asynchronous reset, active high.
    input  wire logic        WB_CYC_I,         // Wishbone cycle.
    input  wire logic        WB_STB_I,         // Wishbone strobe.
    input  wire logic        WB_WE_I,          // Wishbone write enable.
    input  wire logic [7:0]  WB_ADR_I,         // Wishbone byte address.
    input  wire logic [3:0]  WB_SEL_I,         // Wishbone byte lanes.
    input  wire logic [31:0] WB_DAT_I,         // Wishbone write data.
    output logic      [31:0] WB_DAT_O,         // Wishbone read data.
    output logic             WB_ACK_O,         // Wishbone acknowledge.
    output logic      [15:0] ISA_ADDR,         // Instruction bus address.
    input  wire logic [9:0]  ISA_DATA,         // Instruction bus word.
    output logic             SYNC,             // Opcode fetch marker.
    output logic      [1:0]  ROM_BANK,         // Active system bank.
    output logic      [7:0]  FLAG_OUT,         // Flag-out bus.
    input  wire logic [7:0]  KEY_ROW_LINES,    // Keyboard rows.
    input  wire logic        KEY_POWER_LINE,   // Power-on key line.
    input  wire logic [6:0]  KEY_COLUMN_LINES, // Keyboard columns.
    output logic             MC_END            // Machine cycle end pulse.
);
    cbio_key_if  key ();
    logic [9:0]  isa_s1_q;
    logic [9:0]  isa_s2_q;
    logic [9:0]  word_q;
    logic [7:0]  phase_q;
    logic        slow_q;
    logic        mc_end;
    logic        exec_op;
    logic [7:0]  last_ph;
    cbio_fetch_e fetch_q;
    logic [7:0]  lo_q;
    logic [15:0] pc_q;
    logic        carry_q;
    logic        run_q;
    logic        fast_q;
    logic [1:0]  bank_q;
    logic [7:0]  flag_q;
    logic [7:0]  stat_q;
    logic [7:0]  g_q;
    logic [7:0]  g_d;
    logic [55:0] c_q;
    logic [3:0]  ptr_q;
    logic        moved_q;
    logic        ack_q;
    logic [31:0] rdata_q;
    logic        wr;
    logic        sw_wr;

    function automatic logic [3:0] dig(input logic [55:0] c, input logic [3:0] i);
        return (i > TOP_DIGIT) ? 4'h0 : c[{i, 2'b00} +: 4];
    endfunction

    function automatic logic bus_op(input logic [9:0] w);
        return w == OP_DISP_TOGGLE || w == OP_FLAG_LOAD || w == OP_FLAG_XCHG
            || w == OP_KEY_BRANCH || (w[9:8] == BANK_OP_HI && w[5:0] == BANK_OP_LO);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b * 8 +: 8] = nw[b * 8 +: 8];
            end
        end
        return r;
    endfunction

    cbio_keyenc u_keyenc (
        .clk              (CLK),
        .reset            (RESET),
        .key_row_lines    (KEY_ROW_LINES),
        .key_power_line   (KEY_POWER_LINE),
        .key_column_lines (KEY_COLUMN_LINES),
        .key              (key.enc)
    );

    ////////////////////////////////////////////////////////////////////////
    // Machine cycle timing. A bus-speed opcode stretches a fast cycle.
    assign last_ph = (fast_q && !slow_q) ? 8'(FAST_CYC - 1) : 8'(NORMAL_CYC - 1);
    assign mc_end  = run_q && phase_q == last_ph;
    assign exec_op = mc_end && fetch_q == FETCH_OPCODE;
    assign MC_END  = mc_end;
    assign ISA_ADDR = pc_q;
    assign SYNC     = run_q && fetch_q == FETCH_OPCODE;

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            isa_s1_q <= 10'h000;
            isa_s2_q <= 10'h000;
        end else begin
            isa_s1_q <= ISA_DATA;
            isa_s2_q <= isa_s1_q;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            phase_q <= 8'h00;
            word_q  <= 10'h000;
            slow_q  <= 1'b0;
        end else if (!run_q || mc_end) begin
            phase_q <= 8'h00;
            slow_q  <= 1'b0;
        end else begin
            phase_q <= phase_q + 8'h01;
            if (phase_q == 8'(PH_SAMPLE)) begin
                word_q <= isa_s2_q;
                slow_q <= fetch_q == FETCH_OPCODE && bus_op(isa_s2_q);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Program flow. The PC holds this instruction's address until its end.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            fetch_q <= FETCH_OPCODE;
            lo_q    <= RST_BYTE;
        end else if (mc_end) begin
            case (fetch_q)
                FETCH_OPCODE: begin
                    if (word_q[1:0] == LONG_FIRST_TAG) begin
                        lo_q    <= word_q[9:2];
                        fetch_q <= FETCH_SECOND;
                    end
                end
                FETCH_SECOND: fetch_q <= FETCH_OPCODE;
                default:      fetch_q <= FETCH_OPCODE;
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            pc_q <= RST_PC;
        end else if (sw_wr && WB_ADR_I == ADR_PC) begin
            pc_q <= 16'(merge({16'h0000, pc_q}, WB_DAT_I, WB_SEL_I));
        end else if (exec_op && word_q[2:0] == REL_CARRY_TAG && carry_q) begin
            pc_q <= pc_q + {{9{word_q[9]}}, word_q[9:3]};
        end else if (exec_op && word_q == OP_KEY_BRANCH) begin
            pc_q <= {pc_q[15:8], key.key_code};
        end else if (mc_end && fetch_q == FETCH_SECOND
                     && word_q[1:0] == LONG_CARRY_TAG && carry_q) begin
            pc_q <= {word_q[9:2], lo_q};
        end else if (mc_end) begin
            pc_q <= pc_q + 16'h0001;
        end
    end

    // Every instruction of the group leaves carry cleared; a long branch
    // keeps it across its first word so the second word can test it.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            carry_q <= 1'b0;
            run_q   <= 1'b0;
            fast_q  <= 1'b0;
        end else begin
            if (wr && WB_ADR_I == ADR_CTRL && WB_SEL_I[0]) begin
                run_q  <= WB_DAT_I[CTRL_RUN];
                fast_q <= WB_DAT_I[CTRL_FAST];
            end
            if (sw_wr && WB_ADR_I == ADR_CTRL && WB_SEL_I[0]) begin
                carry_q <= WB_DAT_I[CTRL_CARRY];
            end else if (mc_end && !(exec_op && word_q[1:0] == LONG_FIRST_TAG)) begin
                carry_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bank select, taken only while running from a system page.
    assign ROM_BANK = bank_q;

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            bank_q <= RST_BANK;
        end else if (exec_op && word_q[9:8] == BANK_OP_HI && word_q[5:0] == BANK_OP_LO
                     && pc_q[15:12] <= SYS_PAGE_LAST) begin
            bank_q <= {word_q[6], word_q[7]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flag-out bus and low status byte.
    assign FLAG_OUT = flag_q;

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            flag_q <= RST_BYTE;
            stat_q <= RST_BYTE;
        end else if (sw_wr && WB_ADR_I == ADR_STAT && WB_SEL_I[0]) begin
            stat_q <= WB_DAT_I[7:0];
        end else if (exec_op && word_q == OP_FLAG_LOAD) begin
            flag_q <= stat_q;
        end else if (exec_op && word_q == OP_FLAG_XCHG) begin
            flag_q <= stat_q;
            stat_q <= flag_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // G register, C register and pointer.
    always_comb begin
        if (ptr_q != TOP_DIGIT) begin
            g_d = {dig(c_q, ptr_q + 4'h1), dig(c_q, ptr_q)};
        end else if (moved_q) begin
            g_d = {dig(c_q, TOP_DIGIT), g_q[7:4]};
        end else begin
            g_d = {dig(c_q, TOP_DIGIT), dig(c_q, 4'h0)};
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            g_q <= RST_BYTE;
        end else if (sw_wr && WB_ADR_I == ADR_GREG && WB_SEL_I[0]) begin
            g_q <= WB_DAT_I[7:0];
        end else if (exec_op && word_q == OP_G_LOAD) begin
            g_q <= g_d;
        end
    end

    // A pointer write of the top digit stands for a pointer move by the
    // preceding instruction; it lasts until the next instruction ends.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            c_q     <= RST_C;
            ptr_q   <= RST_PTR;
            moved_q <= 1'b0;
        end else if (sw_wr) begin
            if (WB_ADR_I == ADR_C_LO) begin
                c_q[31:0] <= merge(c_q[31:0], WB_DAT_I, WB_SEL_I);
            end
            if (WB_ADR_I == ADR_C_HI) begin
                c_q[55:32] <= 24'(merge({8'h00, c_q[55:32]}, WB_DAT_I, WB_SEL_I));
            end
            if (WB_ADR_I == ADR_PTR && WB_SEL_I[0]) begin
                ptr_q   <= WB_DAT_I[3:0];
                moved_q <= WB_DAT_I[3:0] == TOP_DIGIT;
            end
        end else if (mc_end) begin
            moved_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wishbone slave: one wait state, ack for one cycle, unmapped reads zero.
    assign wr       = WB_CYC_I && WB_STB_I && WB_WE_I && !ack_q;
    assign sw_wr    = wr && !run_q;
    assign WB_ACK_O = ack_q;
    assign WB_DAT_O = rdata_q;

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            ack_q <= WB_CYC_I && WB_STB_I && !ack_q;
            case (WB_ADR_I)
                ADR_CTRL:  rdata_q <= {29'h0, carry_q, fast_q, run_q};
                ADR_PTR:   rdata_q <= {27'h0, moved_q, ptr_q};
                ADR_STAT:  rdata_q <= {24'h0, stat_q};
                ADR_C_LO:  rdata_q <= c_q[31:0];
                ADR_C_HI:  rdata_q <= {8'h00, c_q[55:32]};
                ADR_GREG:  rdata_q <= {24'h0, g_q};
                ADR_PC:    rdata_q <= {16'h0000, pc_q};
                ADR_STATE: rdata_q <= {13'h0, fetch_q, key.key_code, bank_q, flag_q};
                default:   rdata_q <= 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    AST_DISP_NOP: assert property (@(posedge CLK) disable iff (RESET)
        exec_op && word_q == OP_DISP_TOGGLE |=> pc_q == $past(pc_q) + 16'h0001
            && flag_q == $past(flag_q) && g_q == $past(g_q))
        else $error("Display toggle changed processor state.");
    AST_BUS_SPEED: assert property (@(posedge CLK) disable iff (RESET)
        exec_op && bus_op(word_q) |-> phase_q == 8'(NORMAL_CYC - 1))
        else $error("Bus-speed opcode ran in a fast cycle.");
    AST_BANK_SWITCH: assert property (@(posedge CLK) disable iff (RESET)
        exec_op && word_q[9:8] == BANK_OP_HI && word_q[5:0] == BANK_OP_LO
            && pc_q[15:12] <= SYS_PAGE_LAST |=> bank_q == {$past(word_q[6]), $past(word_q[7])})
        else $error("Bank did not switch at the cycle end.");
    AST_FLAG_LOAD: assert property (@(posedge CLK) disable iff (RESET)
        exec_op && word_q == OP_FLAG_LOAD |=> FLAG_OUT == $past(stat_q))
        else $error("Flag-out load lost the status byte.");
    AST_FLAG_XCHG: assert property (@(posedge CLK) disable iff (RESET)
        exec_op && word_q == OP_FLAG_XCHG |=> FLAG_OUT == $past(stat_q)
            && stat_q == $past(flag_q))
        else $error("Flag-out exchange was not simultaneous.");
    AST_G_NORMAL: assert property (@(posedge CLK) disable iff (RESET)
        exec_op && word_q == OP_G_LOAD && ptr_q < TOP_DIGIT |=>
            g_q == {$past(c_q[{ptr_q, 2'b00} + 6'd4 +: 4]), $past(c_q[{ptr_q, 2'b00} +: 4])})
        else $error("G-load took the wrong digits.");
    AST_G_TOP: assert property (@(posedge CLK) disable iff (RESET)
        exec_op && word_q == OP_G_LOAD && ptr_q == TOP_DIGIT && !moved_q |=>
            g_q == {$past(c_q[55:52]), $past(c_q[3:0])})
        else $error("G-load at top digit did not wrap to digit 0.");
    AST_G_TOP_MOVED: assert property (@(posedge CLK) disable iff (RESET)
        exec_op && word_q == OP_G_LOAD && ptr_q == TOP_DIGIT && moved_q |=>
            g_q == {$past(c_q[55:52]), $past(g_q[7:4])})
        else $error("G-load after pointer move did not keep G high nibble.");
    AST_REL_BRANCH: assert property (@(posedge CLK) disable iff (RESET)
        exec_op && word_q[2:0] == REL_CARRY_TAG && carry_q |=>
            pc_q == $past(pc_q) + {{9{$past(word_q[9])}}, $past(word_q[9:3])})
        else $error("Relative branch target wrong.");
    AST_KEY_BRANCH: assert property (@(posedge CLK) disable iff (RESET)
        exec_op && word_q == OP_KEY_BRANCH |=>
            pc_q == {$past(pc_q[15:8]), $past(key.key_code)})
        else $error("Key branch target wrong.");
    AST_LONG_BRANCH: assert property (@(posedge CLK) disable iff (RESET)
        mc_end && fetch_q == FETCH_SECOND && word_q[1:0] == LONG_CARRY_TAG && carry_q
            |=> pc_q == {$past(word_q[9:2]), $past(lo_q)})
        else $error("Long branch target wrong.");
    AST_NO_SYNC_SECOND: assert property (@(posedge CLK) disable iff (RESET)
        exec_op && word_q[1:0] == LONG_FIRST_TAG |=> !SYNC [*2])
        else $error("Fetch marker shown for a second branch word.");
    AST_SYNC_FETCH: assert property (@(posedge CLK) disable iff (RESET)
        mc_end && !(exec_op && word_q[1:0] == LONG_FIRST_TAG) |=> SYNC || !run_q)
        else $error("Fetch marker missing on an opcode fetch.");
endmodule

//--- dv/cbio_mem_model.sv
/* Program memory and display controller model for the decoder core.
   Assumes ISA_ADDR holds for the whole machine cycle. */
`timescale 1ns/1ps
module cbio_mem_model
    import cbio_pkg::*;
(
    input  wire logic        clk,      // System clock.
    input  wire logic [15:0] isa_addr, // Fetch address.
    input  wire logic        sync,     // Opcode fetch marker.
    input  wire logic        mc_end,   // Machine cycle end.
    output logic      [9:0]  isa_data  // Instruction word.
);
    logic [9:0] mem [0:4095];
    int         toggles = 0;
    int         ext_banks = 0;
    initial foreach (mem[i]) mem[i] = 10'h000;
    assign isa_data = mem[isa_addr[11:0]];
    // The display side decodes only words fetched with the marker up.
    // Bank selects off a system page belong to an external ROM module.
    always @(posedge clk) begin
        if (mc_end && sync && isa_data == OP_DISP_TOGGLE) toggles++;
        if (mc_end && sync && isa_data[9:8] == BANK_OP_HI && isa_data[5:0] == BANK_OP_LO
            && isa_addr[15:12] > SYS_PAGE_LAST) ext_banks++;
    end
endmodule

//--- dv/calc_cpu_branch_io_ops_test.sv
/* Self-checking bench for the decoder core.
   Assumes the core answers Wishbone and runs from cbio_mem_model. */
`timescale 1ns/1ps
module calc_cpu_branch_io_ops_test;
    import cbio_pkg::*;
    logic clk = 0, reset = 1, cyc = 0, stb = 0, we = 0, ack, sync, mc, pwr = 0;
    logic [7:0] adr = 8'h00, fo, rows = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, r;
    logic [15:0] ia;
    logic [9:0] id;
    logic [6:0] cols = 7'h00;
    logic [1:0] bank, slog;
    int failures = 0, n_tests = 0, clks = 0;
    cbio_core cbio_core_inst (.CLK(clk), .RESET(reset), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
        .WB_ACK_O(ack), .ISA_ADDR(ia), .ISA_DATA(id), .SYNC(sync), .ROM_BANK(bank),
        .FLAG_OUT(fo), .KEY_ROW_LINES(rows), .KEY_POWER_LINE(pwr),
        .KEY_COLUMN_LINES(cols), .MC_END(mc));
    cbio_mem_model cbio_mem_model_inst (.clk(clk), .isa_addr(ia), .sync(sync),
        .mc_end(mc), .isa_data(id));
    initial forever #10 clk = ~clk;
    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wait_hi(ref logic s);
        int i;
        i = 0;
        do begin @(posedge clk); i++; end while (s !== 1'b1 && i < 40);
        clks = i;
        if (s !== 1'b1) begin failures++; stop_test(); end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        adr <= a; wdat <= d; we <= w; cyc <= 1'b1; stb <= 1'b1;
        wait_hi(ack);
        r = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge clk);
    endtask
    // Starts the core at pc with the given carry and stops it after n cycles.
    task automatic run(input logic [15:0] pc, input logic cy, input int n);
        wb(1, ADR_PC, {16'h0, pc});
        wb(1, ADR_CTRL, {29'h0, cy, 2'h1});
        for (int k = 0; k < n; k++) begin wait_hi(mc); slog = {slog[0], sync}; end
        wb(1, ADR_CTRL, 32'h0);
    endtask
    task automatic t_flag;
        cbio_mem_model_inst.mem[0] = OP_FLAG_LOAD;
        cbio_mem_model_inst.mem[1] = OP_FLAG_XCHG;
        wb(1, ADR_STAT, 32'hA5);
        run(16'h0000, 0, 1);
        chk(fo, 16'hA5);
        wb(1, ADR_STAT, 32'h3C);
        run(16'h0001, 0, 1);
        chk(fo, 16'h3C);
        wb(0, ADR_STAT, 32'h0);
        chk(r[15:0], 16'hA5);
        $display("flag-out test done");
    endtask
    task automatic t_disp_bank;
        cbio_mem_model_inst.mem[16] = OP_DISP_TOGGLE;
        cbio_mem_model_inst.mem[17] = 10'h180;
        cbio_mem_model_inst.mem[12'h020] = 10'h140;
        run(16'h0010, 0, 2);
        chk(ia, 16'h0012);
        chk(slog, 2'b11);
        chk(bank, 2'h1);
        chk(cbio_mem_model_inst.toggles, 1);
        run(16'h4020, 0, 1);
        chk(bank, 2'h1);
        chk(cbio_mem_model_inst.ext_banks, 1);
        $display("display and bank test done");
    endtask
    task automatic t_branch;
        cbio_mem_model_inst.mem[12'h100] = 10'h3F7;
        cbio_mem_model_inst.mem[12'h0FE] = 10'h3F7;
        run(16'h0100, 1, 1);
        chk(ia, 16'h00FE);
        run(16'h00FE, 0, 1);
        chk(ia, 16'h00FF);
        cbio_mem_model_inst.mem[12'h200] = {8'h34, 2'b01};
        cbio_mem_model_inst.mem[12'h201] = {8'h12, 2'b11};
        run(16'h0200, 1, 2);
        chk(ia, 16'h1234);
        chk(slog, 2'b10);
        cbio_mem_model_inst.mem[12'h300] = {8'h00, 2'b01};
        cbio_mem_model_inst.mem[12'h301] = OP_DISP_TOGGLE;
        run(16'h0300, 0, 2);
        chk(ia, 16'h0302);
        chk(cbio_mem_model_inst.toggles, 1);
        rows <= 8'h04;
        cols <= 7'h08;
        cbio_mem_model_inst.mem[12'h234] = OP_KEY_BRANCH;
        run(16'h1234, 0, 1);
        chk(ia, 16'h1282);
        $display("branch test done");
    endtask
    task automatic t_gload;
        cbio_mem_model_inst.mem[12'h061] = OP_G_LOAD;
        wb(1, ADR_C_LO, 32'h76543210);
        wb(1, ADR_C_HI, 32'h00DCBA98);
        wb(1, ADR_PTR, 32'h5);
        run(16'h0061, 0, 1);
        wb(0, ADR_GREG, 32'h0);
        chk(r[15:0], 16'h0065);
        wb(1, ADR_PTR, 32'hC);
        run(16'h0061, 0, 1);
        wb(0, ADR_GREG, 32'h0);
        chk(r[15:0], 16'h00DC);
        wb(1, ADR_PTR, 32'hD);
        run(16'h0060, 0, 2);
        wb(0, ADR_GREG, 32'h0);
        chk(r[15:0], 16'h00D0);
        wb(1, ADR_GREG, 32'h5A);
        wb(1, ADR_PTR, 32'hD);
        run(16'h0061, 0, 1);
        wb(0, ADR_GREG, 32'h0);
        chk(r[15:0], 16'h00D5);
        $display("G-load test done");
    endtask
    // Fast mode: clocks per machine cycle, bus-speed opcodes against a plain one.
    task automatic t_fast;
        cbio_mem_model_inst.mem[12'h041] = OP_FLAG_LOAD;
        cbio_mem_model_inst.mem[12'h042] = OP_DISP_TOGGLE;
        cbio_mem_model_inst.mem[12'h043] = OP_KEY_BRANCH;
        rows <= 8'h00;
        cols <= 7'h01;
        pwr <= 1'b1;
        wb(1, ADR_PC, 32'h40);
        wb(1, ADR_CTRL, 32'h3);
        wait_hi(mc);
        wait_hi(mc);
        chk(clks, NORMAL_CLKS);
        wait_hi(mc);
        chk(clks, NORMAL_CLKS);
        wait_hi(mc);
        chk(clks, NORMAL_CLKS);
        wait_hi(mc);
        chk(clks, FAST_CLKS);
        wb(1, ADR_CTRL, 32'h0);
        chk(fo, 16'h00A5);
        chk(ia, 16'h0019);
        chk(cbio_mem_model_inst.toggles, 2);
        $display("fast mode test done");
    endtask
    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_flag();
        t_disp_bank();
        t_branch();
        t_gload();
        t_fast();
        stop_test();
    end
endmodule
